// ### rtl/tsc_pkg.sv
package tsc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses inside the hub mmio window
    localparam logic [11:0] ADDR_CTRL_ONE  = 12'h0cd8;
    localparam logic [11:0] ADDR_CTRL_TWO  = 12'h0cd9;
    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // field layout
    localparam int          POWER_BIT      = 7;
    localparam int          RSVD_HI_BIT    = 6;
    localparam int          HYST_MSB       = 5;
    localparam int          HYST_LSB       = 2;
    localparam int          RSVD_LO_BIT    = 1;
    localparam int          SEM_BIT        = 0;
    localparam int          RATE_MSB       = 3;
    localparam int          RATE_LSB       = 0;
    localparam int          HYST_W         = 4;
    localparam int          RATE_W         = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values and codes
    localparam logic [7:0]  CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0]  CTRL_TWO_RESET = 8'h00;
    localparam logic [3:0]  HYST_OFF       = 4'h0;
    localparam logic [3:0]  RATE_OFF       = 4'h0;
    localparam logic [3:0]  RATE_2K        = 4'h4;
    localparam logic [3:0]  RATE_3K        = 4'h5;
    localparam logic [3:0]  RATE_4K        = 4'h6;
    localparam logic [3:0]  RATE_6K        = 4'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // sample intervals in memory clocks
    localparam int          RATE_2K_CLKS   = 2048;
    localparam int          RATE_3K_CLKS   = 3072;
    localparam int          RATE_4K_CLKS   = 4096;
    localparam int          RATE_6K_CLKS   = 6144;
    localparam int          CNT_W          = 16;
    localparam int          TEMP_W         = 8;

    // reserved rate codes count as disabled
    function automatic logic rate_enabled(input logic [3:0] code);
        rate_enabled = (code == RATE_2K) || (code == RATE_3K) || (code == RATE_4K) || (code == RATE_6K);
    endfunction

endpackage : tsc_pkg

// ### rtl/tsc_rate_timer.sv
module tsc_rate_timer #(
    parameter int CLKS_2K = tsc_pkg::RATE_2K_CLKS,
    parameter int CLKS_3K = tsc_pkg::RATE_3K_CLKS,
    parameter int CLKS_4K = tsc_pkg::RATE_4K_CLKS,
    parameter int CLKS_6K = tsc_pkg::RATE_6K_CLKS
) (
    input  wire logic                      sys_clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      run_i,
    input  wire logic [tsc_pkg::RATE_W-1:0] rate_code_i,
    output logic                           tick_o
);

    if (CLKS_2K < 2 || CLKS_3K < 2 || CLKS_4K < 2 || CLKS_6K < 2 ||
        CLKS_6K >= (1 << tsc_pkg::CNT_W)) begin : g_chk
        $error("rate counts out of range");
    end

    function automatic logic [tsc_pkg::CNT_W-1:0] rate_limit(input logic [3:0] code);
        case (code)
            tsc_pkg::RATE_2K: rate_limit = tsc_pkg::CNT_W'(CLKS_2K - 1);
            tsc_pkg::RATE_3K: rate_limit = tsc_pkg::CNT_W'(CLKS_3K - 1);
            tsc_pkg::RATE_4K: rate_limit = tsc_pkg::CNT_W'(CLKS_4K - 1);
            tsc_pkg::RATE_6K: rate_limit = tsc_pkg::CNT_W'(CLKS_6K - 1);
            default:          rate_limit = '0;
        endcase
    endfunction

    logic [tsc_pkg::CNT_W-1:0]  count;
    logic [tsc_pkg::CNT_W-1:0]  next_count;
    logic [tsc_pkg::RATE_W-1:0] last_code;
    logic                       next_tick;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_count = count + tsc_pkg::CNT_W'(1);
        next_tick  = 1'b0;
        if (!run_i || !tsc_pkg::rate_enabled(rate_code_i) || rate_code_i != last_code) begin
            next_count = '0;
        end else if (count == rate_limit(rate_code_i)) begin
            next_count = '0;
            next_tick  = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count     <= '0;
            last_code <= tsc_pkg::RATE_OFF;
            tick_o    <= 1'b0;
        end else begin
            count     <= next_count;
            last_code <= rate_code_i;
            tick_o    <= next_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helper: cycles since last tick with a steady running code
    logic [tsc_pkg::CNT_W-1:0] gap;
    logic                      gap_ok;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap    <= '0;
            gap_ok <= 1'b0;
        end else begin
            gap    <= tick_o ? tsc_pkg::CNT_W'(1) : gap + tsc_pkg::CNT_W'(1);
            gap_ok <= tick_o ? 1'b1 : (gap_ok && run_i && rate_code_i == last_code);
        end
    end

    property p_tick_spacing;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick_o && gap_ok && run_i && rate_code_i == last_code) |-> (gap == rate_limit(last_code) + tsc_pkg::CNT_W'(1));
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("sample interval wrong");

    property p_no_tick_when_off;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (!run_i || !tsc_pkg::rate_enabled(rate_code_i)) |=> !tick_o;
    endproperty
    a_no_tick_when_off: assert property (p_no_tick_when_off) else $error("tick while disabled");

endmodule // tsc_rate_timer

// ### rtl/tsc_thermal_ctrl.sv
// Summary of operation
// - control one bit 7 powers the sensor
// - power bit ignores writes while lock set
// - bits 7:1 core reset, semaphore platform reset
// - hysteresis code zero adds no offset
// - nonzero code adds offset once tripped
// - first read gives 0, later reads 1 until bit 0 is written with 1
// - semaphore drives no sensor hardware
// - control two fully reset by core reset
// - rate code zero or reserved disables mode
// - rate codes select 2048/3072/4096/6144 clocks
// - hot and catastrophic compared each sample
// - rate field ignores writes while lock set
// - lock set by write 1, platform reset clears
module tsc_thermal_ctrl #(
    parameter int CLKS_2K = tsc_pkg::RATE_2K_CLKS,
    parameter int CLKS_3K = tsc_pkg::RATE_3K_CLKS,
    parameter int CLKS_4K = tsc_pkg::RATE_4K_CLKS,
    parameter int CLKS_6K = tsc_pkg::RATE_6K_CLKS
) (
    input  wire logic                        sys_clk_i,
    input  wire logic                        nrst_i,
    input  wire logic                        core_power_good_reset_n_i,
    input  wire logic [tsc_pkg::ADDR_W-1:0]  reg_addr_i,
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    input  wire logic [tsc_pkg::DATA_W-1:0]  reg_wdata_i,
    output logic      [tsc_pkg::DATA_W-1:0]  reg_rdata_o,
    output logic                             reg_rvalid_o,
    input  wire logic                        sensor_lock_bit_i,
    input  wire logic [tsc_pkg::TEMP_W-1:0]  sensor_temp_i,
    input  wire logic [tsc_pkg::TEMP_W-1:0]  hot_trip_point_i,
    input  wire logic [tsc_pkg::TEMP_W-1:0]  cat_trip_point_i,
    output logic                             sensor_power_enable_o,
    output logic      [tsc_pkg::HYST_W-1:0]  hysteresis_amount_o,
    output logic      [tsc_pkg::RATE_W-1:0]  thermometer_rate_select_o,
    output logic                             sample_strobe_o,
    output logic                             hot_trip_o,
    output logic                             cat_trip_o
);

    if (tsc_pkg::TEMP_W < tsc_pkg::HYST_W) begin : g_chk
        $error("temperature narrower than hysteresis code");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // address decode
    logic wr_one;
    logic wr_two;
    logic rd_one;
    logic rd_two;
    assign wr_one = reg_wr_i && (reg_addr_i == tsc_pkg::ADDR_CTRL_ONE);
    assign wr_two = reg_wr_i && (reg_addr_i == tsc_pkg::ADDR_CTRL_TWO);
    assign rd_one = reg_rd_i && (reg_addr_i == tsc_pkg::ADDR_CTRL_ONE);
    assign rd_two = reg_rd_i && (reg_addr_i == tsc_pkg::ADDR_CTRL_TWO);

    ////////////////////////////////////////////////////////////////////////////////
    // core power-good registers: power, hysteresis, rate
    logic                       power_en;
    logic [tsc_pkg::HYST_W-1:0] hyst;
    logic [tsc_pkg::RATE_W-1:0] rate;
    logic                       next_power_en;
    logic [tsc_pkg::HYST_W-1:0] next_hyst;
    logic [tsc_pkg::RATE_W-1:0] next_rate;

    always_comb begin
        next_power_en = power_en;
        next_hyst     = hyst;
        next_rate     = rate;
        if (wr_one) begin
            if (!sensor_lock_bit_i) begin
                next_power_en = reg_wdata_i[tsc_pkg::POWER_BIT];
            end
            next_hyst = reg_wdata_i[tsc_pkg::HYST_MSB:tsc_pkg::HYST_LSB];
        end
        if (wr_two && !sensor_lock_bit_i) begin
            next_rate = reg_wdata_i[tsc_pkg::RATE_MSB:tsc_pkg::RATE_LSB];
        end
    end

    always_ff @(posedge sys_clk_i or negedge core_power_good_reset_n_i) begin
        if (!core_power_good_reset_n_i) begin
            power_en <= tsc_pkg::CTRL_ONE_RESET[tsc_pkg::POWER_BIT];
            hyst     <= tsc_pkg::CTRL_ONE_RESET[tsc_pkg::HYST_MSB:tsc_pkg::HYST_LSB];
            rate     <= tsc_pkg::CTRL_TWO_RESET[tsc_pkg::RATE_MSB:tsc_pkg::RATE_LSB];
        end else begin
            power_en <= next_power_en;
            hyst     <= next_hyst;
            rate     <= next_rate;
        end
    end

    assign sensor_power_enable_o     = power_en;
    assign hysteresis_amount_o       = hyst;
    assign thermometer_rate_select_o = rate;

    ////////////////////////////////////////////////////////////////////////////////
    // semaphore and read port on the platform reset
    // the semaphore fans out to the read path only, never to the sensor
    logic                       sem;
    logic                       next_sem;
    logic [tsc_pkg::DATA_W-1:0] next_rdata;
    logic                       next_rvalid;

    always_comb begin
        next_sem = sem;
        if (rd_one) begin
            next_sem = 1'b1;
        end else if (wr_one && reg_wdata_i[tsc_pkg::SEM_BIT]) begin
            next_sem = 1'b0;
        end
    end

    always_comb begin
        next_rdata  = '0;
        next_rvalid = reg_rd_i;
        if (rd_one) begin
            next_rdata[tsc_pkg::POWER_BIT]                  = power_en;
            next_rdata[tsc_pkg::HYST_MSB:tsc_pkg::HYST_LSB] = hyst;
            next_rdata[tsc_pkg::SEM_BIT]                    = sem;
        end else if (rd_two) begin
            next_rdata[tsc_pkg::RATE_MSB:tsc_pkg::RATE_LSB] = rate;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sem          <= tsc_pkg::CTRL_ONE_RESET[tsc_pkg::SEM_BIT];
            reg_rdata_o  <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            sem          <= next_sem;
            reg_rdata_o  <= next_rdata;
            reg_rvalid_o <= next_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sample timer
    logic tick;

    tsc_rate_timer #(
        .CLKS_2K (CLKS_2K),
        .CLKS_3K (CLKS_3K),
        .CLKS_4K (CLKS_4K),
        .CLKS_6K (CLKS_6K)
    ) u_timer (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (core_power_good_reset_n_i),
        .run_i       (power_en),
        .rate_code_i (rate),
        .tick_o      (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // temperature from the analog side, two flop synchroniser
    // a multi-bit word may tear in one sample; the next sample corrects it
    logic [tsc_pkg::TEMP_W-1:0] temp_meta;
    logic [tsc_pkg::TEMP_W-1:0] temp_sync;

    always_ff @(posedge sys_clk_i or negedge core_power_good_reset_n_i) begin
        if (!core_power_good_reset_n_i) begin
            temp_meta <= '0;
            temp_sync <= '0;
        end else begin
            temp_meta <= sensor_temp_i;
            temp_sync <= temp_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // trip comparison with hysteresis
    function automatic logic trip_eval(input logic [tsc_pkg::TEMP_W-1:0] temp,
                                       input logic [tsc_pkg::TEMP_W-1:0] point,
                                       input logic [tsc_pkg::HYST_W-1:0] amount,
                                       input logic                       tripped);
        logic [tsc_pkg::TEMP_W:0] thr;
        thr = {1'b0, point};
        if (tripped) begin
            thr = thr + {{(tsc_pkg::TEMP_W + 1 - tsc_pkg::HYST_W){1'b0}}, amount};
        end
        trip_eval = {1'b0, temp} > thr;
    endfunction

    logic next_hot;
    logic next_cat;
    logic enabled;
    assign enabled = power_en && tsc_pkg::rate_enabled(rate);

    always_comb begin
        next_hot = hot_trip_o;
        next_cat = cat_trip_o;
        if (!enabled) begin
            next_hot = 1'b0;
            next_cat = 1'b0;
        end else if (tick) begin
            next_hot = trip_eval(temp_sync, hot_trip_point_i, hyst, hot_trip_o);
            next_cat = trip_eval(temp_sync, cat_trip_point_i, hyst, cat_trip_o);
        end
    end

    always_ff @(posedge sys_clk_i or negedge core_power_good_reset_n_i) begin
        if (!core_power_good_reset_n_i) begin
            hot_trip_o      <= 1'b0;
            cat_trip_o      <= 1'b0;
            sample_strobe_o <= 1'b0;
        end else begin
            hot_trip_o      <= next_hot;
            cat_trip_o      <= next_cat;
            sample_strobe_o <= tick && enabled;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_power_locked;
        @(posedge sys_clk_i) disable iff (!nrst_i || !core_power_good_reset_n_i)
        (wr_one && sensor_lock_bit_i) |=> (power_en == $past(power_en));
    endproperty
    a_power_locked: assert property (p_power_locked) else $error("power bit written under lock");

    property p_power_write;
        @(posedge sys_clk_i) disable iff (!nrst_i || !core_power_good_reset_n_i)
        (wr_one && !sensor_lock_bit_i) |=> (sensor_power_enable_o == $past(reg_wdata_i[tsc_pkg::POWER_BIT]));
    endproperty
    a_power_write: assert property (p_power_write) else $error("power bit not written");

    property p_rate_locked;
        @(posedge sys_clk_i) disable iff (!nrst_i || !core_power_good_reset_n_i)
        (wr_two && sensor_lock_bit_i) |=> $stable(thermometer_rate_select_o);
    endproperty
    a_rate_locked: assert property (p_rate_locked) else $error("rate written under lock");

    property p_sem_read;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        rd_one |=> (reg_rvalid_o && reg_rdata_o[tsc_pkg::SEM_BIT] == $past(sem) && sem);
    endproperty
    a_sem_read: assert property (p_sem_read) else $error("semaphore read wrong");

    property p_sem_clear;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (wr_one && reg_wdata_i[tsc_pkg::SEM_BIT] && !rd_one) ##1 !rd_one ##1 (rd_one && !reg_wr_i)
            |=> !reg_rdata_o[tsc_pkg::SEM_BIT];
    endproperty
    a_sem_clear: assert property (p_sem_clear) else $error("semaphore not cleared");

    property p_sem_keep;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (!rd_one && !(wr_one && reg_wdata_i[tsc_pkg::SEM_BIT])) |=> (sem == $past(sem));
    endproperty
    a_sem_keep: assert property (p_sem_keep) else $error("semaphore changed");

    property p_reserved_zero;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        rd_one |=> (!reg_rdata_o[tsc_pkg::RSVD_HI_BIT] && !reg_rdata_o[tsc_pkg::RSVD_LO_BIT]);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

    property p_two_upper_zero;
        @(posedge sys_clk_i) disable iff (!nrst_i || !core_power_good_reset_n_i)
        rd_two |=> (reg_rdata_o[tsc_pkg::DATA_W-1:tsc_pkg::RATE_MSB+1] == '0) && (reg_rdata_o[tsc_pkg::RATE_MSB:0] == rate);
    endproperty
    a_two_upper_zero: assert property (p_two_upper_zero) else $error("control two readback wrong");

    property p_no_hyst;
        @(posedge sys_clk_i) disable iff (!nrst_i || !core_power_good_reset_n_i)
        (tick && enabled && hyst == tsc_pkg::HYST_OFF) |=> (hot_trip_o == ($past(temp_sync) > $past(hot_trip_point_i)));
    endproperty
    a_no_hyst: assert property (p_no_hyst) else $error("hysteresis applied at code zero");

    property p_hyst_hold;
        @(posedge sys_clk_i) disable iff (!nrst_i || !core_power_good_reset_n_i)
        (tick && enabled && cat_trip_o) |=>
            (cat_trip_o == ({1'b0, $past(temp_sync)} > ({1'b0, $past(cat_trip_point_i)} + {5'h00, $past(hyst)})));
    endproperty
    a_hyst_hold: assert property (p_hyst_hold) else $error("hysteresis offset wrong");

    property p_trip_only_on_tick;
        @(posedge sys_clk_i) disable iff (!nrst_i || !core_power_good_reset_n_i)
        (!tick && enabled) |=> ($stable(hot_trip_o) && $stable(cat_trip_o));
    endproperty
    a_trip_only_on_tick: assert property (p_trip_only_on_tick) else $error("trip changed between samples");

    property p_off_clears;
        @(posedge sys_clk_i) disable iff (!nrst_i || !core_power_good_reset_n_i)
        !tsc_pkg::rate_enabled(rate) |=> (!hot_trip_o && !cat_trip_o && !sample_strobe_o);
    endproperty
    a_off_clears: assert property (p_off_clears) else $error("trip active while disabled");

    // hysteresis is not lockable, so a write lands even under lock
    property p_hyst_write;
        @(posedge sys_clk_i) disable iff (!nrst_i || !core_power_good_reset_n_i)
        wr_one |=> (hysteresis_amount_o == $past(reg_wdata_i[tsc_pkg::HYST_MSB:tsc_pkg::HYST_LSB]));
    endproperty
    a_hyst_write: assert property (p_hyst_write) else $error("hysteresis not written");

    property p_strobe_needs_enable;
        @(posedge sys_clk_i) disable iff (!nrst_i || !core_power_good_reset_n_i)
        sample_strobe_o |-> $past(enabled);
    endproperty
    a_strobe_needs_enable: assert property (p_strobe_needs_enable) else $error("strobe while disabled");

endmodule // tsc_thermal_ctrl

// ### tb/tsc_sensor_model.sv
module tsc_sensor_model (
    input  wire logic       sys_clk_i,
    input  wire logic       power_i,
    input  wire logic [7:0] temp_set_i,
    output logic      [7:0] temp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] junk = 8'h5a;
    // an unpowered diode gives no reading; a moving pattern keeps a stale value from matching
    always @(posedge sys_clk_i) begin
        junk <= ~junk ^ 8'h21;
    end
    assign temp_o = power_i ? temp_set_i : junk;
endmodule // tsc_sensor_model

// ### tb/tsc_thermal_ctrl_test.sv
module tsc_thermal_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] ONE = tsc_pkg::ADDR_CTRL_ONE;
    localparam logic [11:0] TWO = tsc_pkg::ADDR_CTRL_TWO;
    logic        sys_clk_i = 1'b0;
    logic        nrst_i    = 1'b0;
    logic        core_n    = 1'b0;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic        lock      = 1'b0;
    logic [11:0] addr      = 12'h0000;
    logic [7:0]  wdata     = 8'h00;
    logic [7:0]  temp_set  = 8'h32;
    logic [7:0]  hot_pt    = 8'h5f;
    logic [7:0]  cat_pt    = 8'h64;
    logic [7:0]  rdata, temp;
    logic [3:0]  hyst, rate;
    logic        rvalid, pwr, strobe, hot, cat;
    logic [31:0] seed = 32'hc2f2_9247;
    int          mismatches = 0;
    int          compares = 0;
    int          m_pwr, m_hyst, m_rate, m_sem, c, n;
    int          n_tab[4] = '{8, 12, 16, 24};

    always #10 sys_clk_i = ~sys_clk_i;

    tsc_thermal_ctrl #(.CLKS_2K(8), .CLKS_3K(12), .CLKS_4K(16), .CLKS_6K(24)) i_dut (
        .sys_clk_i                 (sys_clk_i),
        .nrst_i                    (nrst_i),
        .core_power_good_reset_n_i (core_n),
        .reg_addr_i                (addr),
        .reg_wr_i                  (wr),
        .reg_rd_i                  (rd),
        .reg_wdata_i               (wdata),
        .reg_rdata_o               (rdata),
        .reg_rvalid_o              (rvalid),
        .sensor_lock_bit_i         (lock),
        .sensor_temp_i             (temp),
        .hot_trip_point_i          (hot_pt),
        .cat_trip_point_i          (cat_pt),
        .sensor_power_enable_o     (pwr),
        .hysteresis_amount_o       (hyst),
        .thermometer_rate_select_o (rate),
        .sample_strobe_o           (strobe),
        .hot_trip_o                (hot),
        .cat_trip_o                (cat)
    );
    tsc_sensor_model i_sensor (
        .sys_clk_i  (sys_clk_i),
        .power_i    (pwr),
        .temp_set_i (temp_set),
        .temp_o     (temp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] m_read(input logic [11:0] a);
        if (a == ONE) return {m_pwr[0], 1'b0, m_hyst[3:0], 1'b0, m_sem[0]};
        if (a == TWO) return {4'h0, m_rate[3:0]};
        return 8'h00;
    endfunction
    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_flag(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %b seen %b", nm, e, g);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic do_reset(input bit plat, input bit core);
        @(negedge sys_clk_i);
        if (plat) nrst_i = 1'b0;
        if (core) core_n = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        core_n = 1'b1;
        // the lock lives outside this block and falls with the platform reset
        if (plat) lock = 1'b0;
        if (plat) m_sem = 0;
        if (core) {m_pwr, m_hyst, m_rate} = '0;
    endtask
    task automatic rd_chk(input logic [11:0] a);
        @(negedge sys_clk_i);
        addr = a;
        rd = 1'b1;
        @(negedge sys_clk_i);
        rd = 1'b0;
        chk_flag("rvalid", 1'b1, rvalid);
        chk_reg("rdata", m_read(a), rdata);
        if (a == ONE) m_sem = 1;
    endtask
    task automatic wr_chk(input logic [11:0] a, input logic [7:0] v);
        @(negedge sys_clk_i);
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(negedge sys_clk_i);
        wr = 1'b0;
        if (a == ONE) begin
            if (!lock) m_pwr = v[7];
            m_hyst = v[5:2];
            if (v[0]) m_sem = 0;
        end else if (a == TWO && !lock) m_rate = v[3:0];
        chk_flag("power", m_pwr[0], pwr);
        chk_reg("hyst", {4'h0, m_hyst[3:0]}, {4'h0, hyst});
        chk_reg("rate", {4'h0, m_rate[3:0]}, {4'h0, rate});
    endtask
    task automatic wait_strobe(output int k);
        k = 0;
        do begin
            @(negedge sys_clk_i);
            k++;
        end while (strobe !== 1'b1 && k < 100);
    endtask
    // trips judged at each strobe; temperature moves just after a strobe so it has settled
    task automatic trip_run(input logic [3:0] h);
        int eh;
        int ec;
        eh = 0;
        ec = 0;
        wr_chk(TWO, 8'h00);
        wr_chk(ONE, {2'b10, h, 2'b00});
        wr_chk(TWO, 8'h04);
        repeat (10) begin
            temp_set = 8'h5a + 8'(xs() % 20);
            wait_strobe(c);
            eh = int'(temp_set) > int'(hot_pt) + (eh != 0 ? int'(h) : 0);
            ec = int'(temp_set) > int'(cat_pt) + (ec != 0 ? int'(h) : 0);
            chk_flag("hot_trip", eh[0], hot);
            chk_flag("cat_trip", ec[0], cat);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        mismatches++;
        print_verdict();
    end
    initial begin
        {m_pwr, m_hyst, m_rate, m_sem} = '0;
        do_reset(1, 1);
        rd_chk(ONE);
        rd_chk(ONE);
        rd_chk(TWO);
        rd_chk(12'h0cda);
        wr_chk(ONE, 8'h01);
        rd_chk(ONE);
        wr_chk(ONE, 8'h00);
        rd_chk(ONE);
        wr_chk(ONE, 8'hff);
        rd_chk(ONE);
        wr_chk(TWO, 8'hf4);
        rd_chk(TWO);
        for (int i = 0; i < 4; i++) begin
            wr_chk(TWO, 8'(4 + i));
            // a tick of the old rate may still leave as a strobe; skip it before timing
            wait_strobe(c);
            wait_strobe(c);
            wait_strobe(c);
            chk_reg("gap", 8'(n_tab[i]), 8'(c));
        end
        trip_run(4'h6);
        trip_run(4'h0);
        repeat (4) begin
            n = int'(xs() % 12);
            wr_chk(TWO, 8'(n < 3 ? n + 1 : n + 5));
            n = 0;
            repeat (40) begin
                @(negedge sys_clk_i);
                if (strobe === 1'b1) n++;
            end
            chk_reg("strobes", 8'h00, 8'(n));
            chk_flag("hot_trip", 1'b0, hot);
        end
        @(negedge sys_clk_i);
        lock = 1'b1;
        wr_chk(ONE, 8'h04);
        wr_chk(TWO, 8'h07);
        do_reset(1, 0);
        rd_chk(ONE);
        wr_chk(ONE, m_read(ONE) | 8'h01);
        rd_chk(ONE);
        do_reset(0, 1);
        rd_chk(ONE);
        rd_chk(TWO);
        print_verdict();
    end
endmodule // tsc_thermal_ctrl_test
